// >>> bench/bcslm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcslm_far_model (
  input wire logic i_ref_clk,
  input wire logic i_ref_on,
  input wire logic i_meas_req,
  input wire logic [8:0] i_code,
  output logic o_ref,
  output logic o_ready,
  output logic [8:0] o_code
);
  logic [3:0] dly_ff;
  // 2.5 MHz reference, phase unrelated, still while off
  initial begin
    o_ref = 1'b0;
    #13;
    forever begin
      #200;
      o_ref = i_ref_on ? ~o_ref : 1'b0;
    end
  end
  // converter answers a few cycles after the request
  always_ff @(posedge i_ref_clk) begin
    dly_ff <= i_meas_req ? ((dly_ff == 4'hF) ? dly_ff : dly_ff + 4'h1) : 4'h0;
  end
  assign o_ready = (dly_ff > 4'h7);
  // code is only meaningful while ready
  assign o_code = o_ready ? i_code : ~i_code;
endmodule
`default_nettype wire

// >>> bench/bcslm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bcslm_checker
  import bcslm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [7:0] o_buck0_ctrl,
  input wire logic o_meas_req,
  input wire logic o_meas_core,
  input wire logic [1:0] o_pwm_mode,
  input wire logic o_ext_clk_sel,
  input wire logic o_pll_enable,
  input wire logic o_freq_dither_enable,
  input wire logic o_host_ready
);
  logic take;
  logic launch;
  logic [10:0] req_cnt_ff;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // request taken, and a measurement launch among them
  assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign launch = take & i_wb_we & i_wb_sel[0] & o_host_ready & (i_wb_adr == ADR_MEAS_SEL);
  // cycles the conversion request has stood
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_cnt_ff <= 11'h000;
    end else begin
      req_cnt_ff <= o_meas_req ? req_cnt_ff + 11'h001 : 11'h000;
    end
  end
  a_ack_answer: assert property (take |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_core_select: assert property (launch |-> ##2 o_meas_core == $past(i_wb_dat[0], 2))
    else $error("measured core differs from selector");
  a_meas_pwm: assert property (launch |-> ##2 o_pwm_mode[$past(i_wb_dat[0], 2)])
    else $error("measured core not forced to pwm");
  a_req_pwm: assert property (o_meas_req |-> o_pwm_mode[o_meas_core])
    else $error("pfm allowed during conversion");
  a_meas_bound: assert property (req_cnt_ff < 11'h321)
    else $error("measurement overran its deadline");
  a_dither_rc: assert property (o_freq_dither_enable |-> !o_pll_enable)
    else $error("dither with pll enabled");
  a_ext_pll: assert property (o_ext_clk_sel |-> o_pll_enable)
    else $error("external clock used with pll off");
  a_fpwm_hold: assert property (o_buck0_ctrl[0] && $past(o_buck0_ctrl[0]) |-> o_pwm_mode[0])
    else $error("forced pwm core left pwm");
endmodule
bind bcslm_core bcslm_checker bcslm_checker_inst (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_buck0_ctrl(o_buck0_ctrl),
  .o_meas_req(o_meas_req), .o_meas_core(o_meas_core), .o_pwm_mode(o_pwm_mode),
  .o_ext_clk_sel(o_ext_clk_sel), .o_pll_enable(o_pll_enable),
  .o_freq_dither_enable(o_freq_dither_enable), .o_host_ready(o_host_ready)
);
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bcslm_pkg::*;
  logic clk, rst_n, cyc, stb, we, bena, rf_on, ack, mreq, mcore, rdy, rf, xsel, pllo, dith;
  logic hrdy, irq;
  logic [7:0] adr, otp, v0, v1, c0, c1, d0, d1;
  logic [3:0] sel;
  logic [31:0] wdat, rd, rdat;
  logic [1:0] ld, pwm;
  logic [8:0] code, mcode;
  logic [7:0] zadr [5] = '{ADR_MASK_TOP, ADR_PLL_CTRL, ADR_CONFIG, ADR_LOAD_LO, 8'h3C};
  int n_errors, checks, cyc_n, i;
  bcslm_core #(.P_HOST_WAIT_CYC(20)) bcslm_core_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_otp_vout0(otp), .i_otp_vout1(otp + 8'h01), .i_otp_ctrl0(otp + 8'h02),
    .i_otp_ctrl1(otp + 8'h03), .i_otp_delay0(otp + 8'h04), .i_otp_delay1(otp + 8'h05),
    .i_ref_clock_input(rf), .i_buck_en_req(bena), .i_load_above_pwm(ld), .i_meas_ready(rdy),
    .i_meas_code(mcode), .o_meas_req(mreq), .o_meas_core(mcore), .o_pwm_mode(pwm),
    .o_ext_clk_sel(xsel), .o_pll_enable(pllo), .o_freq_dither_enable(dith), .o_buck0_vout(v0),
    .o_buck1_vout(v1), .o_buck0_ctrl(c0), .o_buck1_ctrl(c1), .o_buck0_delay(d0),
    .o_buck1_delay(d1), .o_host_ready(hrdy), .o_irq(irq)
  );
  bcslm_far_model bcslm_far_model_inst (
    .i_ref_clk(clk), .i_ref_on(rf_on), .i_meas_req(mreq), .i_code(code), .o_ref(rf),
    .o_ready(rdy), .o_code(mcode)
  );
  // system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic close_out();
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    // wait ends on ack; the hang guard ends a wait that never sees one
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 12000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {cyc, stb, we, bena, rf_on, rst_n} = 6'h00;
    {adr, wdat, ld} = '0;
    sel = 4'hF;
    otp = 8'h5A;
    code = 9'h1A5;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 100 && hrdy !== 1'b1; i++) @(posedge clk);
    chk("vout0", 32'h5A, v0);
    chk("vout1", 32'h5B, v1);
    chk("ctrl0", 32'h5C, c0);
    chk("delay0", 32'h5E, d0);
    chk("ctrl1", 32'h5D, c1);
    chk("delay1", 32'h5F, d1);
    wb(0, ADR_STATUS, 8'h00);
    chk("status", 32'h08, rd);
    for (i = 0; i < 5; i++) begin
      wb(0, zadr[i], 8'h00);
      chk("reset value", 32'h0, rd);
    end
    ld <= 2'b01;
    repeat (6) @(posedge clk);
    chk("pwm heavy", 32'h3, pwm);
    ld <= 2'b00;
    repeat (6) @(posedge clk);
    chk("pwm light", 32'h2, pwm);
    wb(1, ADR_MEAS_SEL, 8'h00);
    for (i = 0; i < 400 && mreq !== 1'b1; i++) @(posedge clk);
    chk("meas req", 32'h1, mreq);
    chk("core", 32'h0, mcore);
    chk("pwm meas", 32'h3, pwm);
    for (i = 0; i < 900 && mreq !== 1'b0; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    chk("pwm after", 32'h2, pwm);
    chk("irq", 32'h1, irq);
    wb(0, ADR_LOAD_LO, 8'h00);
    chk("load lo", 32'hA5, rd);
    wb(0, ADR_LOAD_HI, 8'h00);
    chk("load hi", 32'h1, rd);
    wb(0, ADR_INT_TOP, 8'h00);
    chk("flags", 32'h1, rd);
    wb(1, ADR_MASK_TOP, 8'h01);
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, irq);
    wb(1, ADR_INT_TOP, 8'h01);
    code <= 9'h04B;
    wb(1, ADR_MEAS_SEL, 8'h01);
    repeat (4) @(posedge clk);
    chk("core", 32'h1, mcore);
    wb(0, ADR_LOAD_LO, 8'h00);
    chk("held lo", 32'hA5, rd);
    for (i = 0; i < 1100 && (mreq !== 1'b0 || i < 300); i++) @(posedge clk);
    wb(0, ADR_LOAD_LO, 8'h00);
    chk("new lo", 32'h4B, rd);
    wb(0, ADR_LOAD_HI, 8'h00);
    chk("new hi", 32'h0, rd);
    wb(1, ADR_INT_TOP, 8'h03);
    wb(1, ADR_CONFIG, 8'h01);
    repeat (3) @(posedge clk);
    chk("dither", 32'h1, dith);
    rf_on <= 1'b1;
    wb(1, ADR_PLL_CTRL, 8'h82);
    repeat (3) @(posedge clk);
    chk("dither pll", 32'h0, dith);
    chk("pll out", 32'h1, pllo);
    for (i = 0; i < 800 && xsel !== 1'b1; i++) @(posedge clk);
    chk("ext sel", 32'h1, xsel);
    wb(0, ADR_INT_TOP, 8'h00);
    chk("sync appear", 32'h2, rd);
    wb(1, ADR_INT_TOP, 8'h02);
    wb(1, ADR_PLL_CTRL, 8'h80);
    for (i = 0; i < 800 && xsel !== 1'b0; i++) @(posedge clk);
    chk("out of window", 32'h0, xsel);
    wb(0, ADR_INT_TOP, 8'h00);
    chk("sync vanish", 32'h2, rd);
    wb(1, ADR_INT_TOP, 8'h02);
    rf_on <= 1'b0;
    bena <= 1'b1;
    repeat (20) @(posedge clk);
    wb(0, ADR_INT_TOP, 8'h00);
    chk("sync missing", 32'h2, rd);
    chk("irq sync", 32'h1, irq);
    wb(1, ADR_MASK_TOP, 8'h03);
    repeat (3) @(posedge clk);
    chk("irq sync masked", 32'h0, irq);
    // forced pwm on core 0 holds pwm at light load
    wb(1, ADR_CTRL0, 8'h01);
    repeat (3) @(posedge clk);
    chk("ctrl0 write", 32'h01, c0);
    chk("pwm forced", 32'h3, pwm);
    // pll off: internal clock again, dither returns
    wb(1, ADR_PLL_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk("pll off", 32'h0, pllo);
    chk("ext sel off", 32'h0, xsel);
    chk("dither rc", 32'h1, dith);
    close_out();
  end
endmodule
`default_nettype wire

// >>> core/bcslm_core.sv
`timescale 1ns/1ps
`default_nettype none
module bcslm_core
  import bcslm_pkg::*;
#(
  parameter int unsigned P_HOST_WAIT_CYC = HOST_WAIT_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // classic wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // otp defaults
  input wire logic [7:0] i_otp_vout0,
  input wire logic [7:0] i_otp_vout1,
  input wire logic [7:0] i_otp_ctrl0,
  input wire logic [7:0] i_otp_ctrl1,
  input wire logic [7:0] i_otp_delay0,
  input wire logic [7:0] i_otp_delay1,
  // analog and pin side
  input wire logic i_ref_clock_input,
  input wire logic i_buck_en_req,
  input wire logic [1:0] i_load_above_pwm,
  input wire logic i_meas_ready,
  input wire logic [8:0] i_meas_code,
  output logic o_meas_req,
  output logic o_meas_core,
  output logic [1:0] o_pwm_mode,
  output logic o_ext_clk_sel,
  output logic o_pll_enable,
  output logic o_freq_dither_enable,
  output logic [7:0] o_buck0_vout,
  output logic [7:0] o_buck1_vout,
  output logic [7:0] o_buck0_ctrl,
  output logic [7:0] o_buck1_ctrl,
  output logic [7:0] o_buck0_delay,
  output logic [7:0] o_buck1_delay,
  output logic o_host_ready,
  output logic o_irq
);
  typedef enum logic [1:0] {P_POR, P_OTP, P_STANDBY, P_ACTIVE} bcslm_pwr_t;
  typedef enum logic [1:0] {M_IDLE, M_SETTLE, M_CONV} bcslm_meas_t;

  // two-stage synchronisers for outside inputs
  logic [13:0] sync1_ff;
  logic [13:0] sync2_ff;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_ff <= 14'h0000;
      sync2_ff <= 14'h0000;
    end else if (i_clk_en) begin
      sync1_ff <= {i_meas_code, i_load_above_pwm, i_meas_ready, i_buck_en_req,
                   i_ref_clock_input};
      sync2_ff <= sync1_ff;
    end
  end
  logic ref_s;
  logic buck_en_s;
  logic meas_rdy_s;
  logic [1:0] load_hi_s;
  logic [8:0] code_s;
  assign ref_s = sync2_ff[0];
  assign buck_en_s = sync2_ff[1];
  assign meas_rdy_s = sync2_ff[2];
  assign load_hi_s = sync2_ff[4:3];
  assign code_s = sync2_ff[13:5];

  // bus request decode
  logic req;
  logic wr;
  logic wr_lane;
  logic [7:0] wdat;
  logic ack_ff;
  assign req = i_wb_cyc & i_wb_stb & ~ack_ff;
  assign wr = req & i_wb_we & o_host_ready;
  assign wr_lane = wr & i_wb_sel[0];
  assign wdat = i_wb_dat[7:0];

  // power-up states and host wait
  bcslm_pwr_t pwr_ff;
  logic [4:0] otp_cnt_ff;
  logic [15:0] host_cnt_ff;
  logic otp_done;
  logic to_standby;
  logic to_active;
  assign otp_done = (pwr_ff == P_OTP) && (otp_cnt_ff == 5'(OTP_LOAD_CYC - 1));
  assign to_standby = otp_done;
  assign to_active = (pwr_ff == P_STANDBY) && buck_en_s;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_ff <= P_POR;
      otp_cnt_ff <= 5'h00;
    end else if (i_clk_en) begin
      unique case (pwr_ff)
        P_POR: pwr_ff <= P_OTP;
        P_OTP: begin
          otp_cnt_ff <= otp_cnt_ff + 5'h01;
          if (otp_done) begin
            pwr_ff <= P_STANDBY; // [RL21]
          end
        end
        P_STANDBY: if (to_active) begin
          pwr_ff <= P_ACTIVE;
        end
        P_ACTIVE: if (!buck_en_s) begin
          pwr_ff <= P_STANDBY;
        end
      endcase
    end
  end

  // host access gate after supply release
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_cnt_ff <= 16'h0000;
      o_host_ready <= 1'b0;
    end else if (i_clk_en) begin
      if (!o_host_ready) begin
        host_cnt_ff <= host_cnt_ff + 16'h0001;
      end
      if (host_cnt_ff == 16'(P_HOST_WAIT_CYC - 1)) begin
        o_host_ready <= 1'b1; // [RL20]
      end
    end
  end

  // converter settings, defaults from otp at load
  logic [7:0] vout_ff [2];
  logic [7:0] ctrl_ff [2];
  logic [7:0] delay_ff [2];
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vout_ff[0] <= 8'h00;
      vout_ff[1] <= 8'h00;
      ctrl_ff[0] <= 8'h00;
      ctrl_ff[1] <= 8'h00;
      delay_ff[0] <= 8'h00;
      delay_ff[1] <= 8'h00;
    end else if (i_clk_en) begin
      if (otp_done) begin
        vout_ff[0] <= i_otp_vout0; // [RL19]
        vout_ff[1] <= i_otp_vout1;
        ctrl_ff[0] <= i_otp_ctrl0;
        ctrl_ff[1] <= i_otp_ctrl1;
        delay_ff[0] <= i_otp_delay0;
        delay_ff[1] <= i_otp_delay1;
      end else if (wr_lane) begin
        unique case (i_wb_adr)
          ADR_VOUT0: vout_ff[0] <= wdat;
          ADR_VOUT1: vout_ff[1] <= wdat;
          ADR_CTRL0: ctrl_ff[0] <= wdat;
          ADR_CTRL1: ctrl_ff[1] <= wdat;
          ADR_DELAY0: delay_ff[0] <= wdat;
          ADR_DELAY1: delay_ff[1] <= wdat;
          default: ;
        endcase
      end
    end
  end

  // clock, mask and dither configuration
  logic pll_en_ff;
  logic [4:0] ref_sel_ff;
  logic dither_ff;
  logic [1:0] mask_ff;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pll_en_ff <= PLL_EN_RST;
      ref_sel_ff <= REF_SEL_RST;
      dither_ff <= DITHER_RST;
      mask_ff <= MASK_RST;
    end else if (i_clk_en && wr_lane) begin
      if (i_wb_adr == ADR_PLL_CTRL) begin
        pll_en_ff <= wdat[PLL_EN_BIT];
        ref_sel_ff <= wdat[4:0]; // [RL11]
      end
      if (i_wb_adr == ADR_CONFIG) begin
        dither_ff <= wdat[0]; // [RL10]
      end
      if (i_wb_adr == ADR_MASK_TOP) begin
        mask_ff <= wdat[1:0];
      end
    end
  end

  // reference frequency check over a fixed window
  logic ref_d_ff;
  logic [7:0] win_cnt_ff;
  logic [8:0] edge_cnt_ff;
  logic ref_valid_ff;
  logic [4:0] nom_mhz;
  logic [8:0] lo_lim;
  logic [8:0] hi_lim;
  logic win_end;
  assign nom_mhz = (ref_sel_ff > REF_SEL_MAX) ? 5'h18 : ref_sel_ff + 5'h01;
  assign lo_lim = 9'(nom_mhz * (WIN_NS / 1000) * REF_LO_PCT / 100);
  assign hi_lim = 9'(nom_mhz * (WIN_NS / 1000) * REF_HI_PCT / 100);
  assign win_end = win_cnt_ff == 8'(WIN_CYC - 1);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_d_ff <= 1'b0;
      win_cnt_ff <= 8'h00;
      edge_cnt_ff <= 9'h000;
      ref_valid_ff <= 1'b0;
    end else if (i_clk_en) begin
      ref_d_ff <= ref_s;
      win_cnt_ff <= win_end ? 8'h00 : win_cnt_ff + 8'h01;
      if (win_end) begin
        edge_cnt_ff <= 9'h000;
        ref_valid_ff <= (edge_cnt_ff >= lo_lim) && (edge_cnt_ff <= hi_lim); // [RL12]
      end else if (ref_s && !ref_d_ff && edge_cnt_ff != 9'h1FF) begin
        edge_cnt_ff <= edge_cnt_ff + 9'h001;
      end
    end
  end

  // measurement sequencer
  bcslm_meas_t meas_ff;
  logic [9:0] meas_cnt_ff;
  logic meas_sel_ff;
  logic [8:0] result_ff;
  logic launch;
  logic meas_fin;
  assign launch = wr_lane && (i_wb_adr == ADR_MEAS_SEL); // [RL2]
  assign meas_fin = (meas_ff == M_CONV) &&
                    (meas_rdy_s || meas_cnt_ff == 10'(MEAS_CYC - 1)); // [RL4]
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meas_ff <= M_IDLE;
      meas_cnt_ff <= 10'h000;
      meas_sel_ff <= 1'b0;
      o_meas_req <= 1'b0;
    end else if (i_clk_en) begin
      if (launch) begin
        meas_sel_ff <= wdat[0]; // [RL1]
        meas_ff <= M_SETTLE;
        meas_cnt_ff <= 10'h000;
        o_meas_req <= 1'b0;
      end else begin
        unique case (meas_ff)
          M_IDLE: meas_cnt_ff <= 10'h000;
          M_SETTLE: begin
            meas_cnt_ff <= meas_cnt_ff + 10'h001;
            if (meas_cnt_ff == 10'(SETTLE_CYC - 1)) begin
              meas_ff <= M_CONV;
              o_meas_req <= 1'b1;
            end
          end
          M_CONV: begin
            meas_cnt_ff <= meas_cnt_ff + 10'h001;
            if (meas_fin) begin
              meas_ff <= M_IDLE;
              o_meas_req <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // result captured only at completion, 20 mA per step
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_ff <= 9'h000;
    end else if (i_clk_en && meas_fin && !launch) begin
      result_ff <= code_s; // [RL8] [RL22]
    end
  end

  // sticky flags, set beats clear
  logic [1:0] flags_ff;
  logic [1:0] set_ev;
  logic [1:0] clr;
  logic ref_valid_d_ff;
  logic pll_live;
  assign pll_live = pll_en_ff && (pwr_ff == P_STANDBY || pwr_ff == P_ACTIVE);
  always_comb begin
    set_ev = 2'h0;
    set_ev[FLAG_MEAS] = meas_fin && !launch; // [RL5]
    set_ev[FLAG_SYNC] = (pll_live && ref_valid_ff != ref_valid_d_ff) || // [RL14]
                        (pll_en_ff && !ref_valid_ff && (to_standby || to_active)); // [RL15]
    clr = (wr_lane && i_wb_adr == ADR_INT_TOP) ? wdat[1:0] : 2'h0;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_ff <= 2'h0;
      ref_valid_d_ff <= 1'b0;
    end else if (i_clk_en) begin
      ref_valid_d_ff <= ref_valid_ff;
      flags_ff <= (flags_ff & ~clr) | set_ev;
    end
  end

  // registered interrupt and outputs to the converter cores
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
      o_pwm_mode <= 2'h0;
      o_ext_clk_sel <= 1'b0;
      o_pll_enable <= 1'b0;
      o_freq_dither_enable <= 1'b0;
      o_meas_core <= 1'b0;
    end else if (i_clk_en) begin
      o_irq <= |(flags_ff & ~mask_ff); // [RL6] [RL16]
      for (int i = 0; i < 2; i++) begin
        // pwm when forced, measured, or above load threshold
        o_pwm_mode[i] <= ctrl_ff[i][CTRL_FPWM_BIT] || // [RL18]
                         (meas_ff != M_IDLE && meas_sel_ff == 1'(i)) || // [RL3]
                         load_hi_s[i]; // [RL17]
      end
      o_ext_clk_sel <= pll_live && ref_valid_ff; // [RL13]
      o_pll_enable <= pll_en_ff;
      o_freq_dither_enable <= dither_ff && !pll_en_ff; // [RL9] [RL10]
      o_meas_core <= meas_sel_ff;
    end
  end
  assign o_buck0_vout = vout_ff[0];
  assign o_buck1_vout = vout_ff[1];
  assign o_buck0_ctrl = ctrl_ff[0];
  assign o_buck1_ctrl = ctrl_ff[1];
  assign o_buck0_delay = delay_ff[0];
  assign o_buck1_delay = delay_ff[1];

  // bus read mux and ack
  logic [7:0] rdat;
  always_comb begin
    unique case (i_wb_adr)
      ADR_MEAS_SEL: rdat = {6'h00, meas_ff != M_IDLE, meas_sel_ff};
      ADR_LOAD_LO: rdat = result_ff[7:0]; // [RL7]
      ADR_LOAD_HI: rdat = {7'h00, result_ff[8]}; // [RL7]
      ADR_INT_TOP: rdat = {6'h00, flags_ff};
      ADR_MASK_TOP: rdat = {6'h00, mask_ff};
      ADR_PLL_CTRL: rdat = {pll_en_ff, 2'h0, ref_sel_ff};
      ADR_CONFIG: rdat = {7'h00, dither_ff};
      ADR_STATUS: rdat = {4'h0, pwr_ff, o_ext_clk_sel, ref_valid_ff};
      ADR_VOUT0: rdat = vout_ff[0];
      ADR_VOUT1: rdat = vout_ff[1];
      ADR_CTRL0: rdat = ctrl_ff[0];
      ADR_CTRL1: rdat = ctrl_ff[1];
      ADR_DELAY0: rdat = delay_ff[0];
      ADR_DELAY1: rdat = delay_ff[1];
      default: rdat = 8'h00;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else if (i_clk_en) begin
      ack_ff <= req;
      if (req) begin
        o_wb_dat <= (i_wb_we || !o_host_ready) ? 32'h00000000 : {24'h000000, rdat};
      end
    end
  end
  assign o_wb_ack = ack_ff;
endmodule
`default_nettype wire

// >>> include/bcslm_pkg.sv
// Operation
// RL1: one selector bit picks measured core
// RL2: each selector write launches a measurement
// RL3: measured core forced PWM, then restored
// RL4: measurement completes within 50 us
// RL5: completion sets measurement-done flag
// RL6: mask bit gates measurement-done interrupt
// RL7: result low byte plus separate top bit
// RL8: result unsigned, 20 mA per step
// RL9: dithering only while PLL enable clear
// RL10: one dither bit drives both cores
// RL11: five-bit field selects 1..24 MHz nominal
// RL12: reference valid within -30%/+10% window
// RL13: PLL enabled selects valid reference automatically
// RL14: reference appear/disappear sets sync flag
// RL15: missing reference at transitions sets flag
// RL16: mask bit gates sync-clock interrupt
// RL17: auto mode: PFM light, PWM above 600mA
// RL18: forced PWM never enters PFM
// RL19: converter settings reset from OTP bits
// RL20: host waits 1.2 ms before access
// RL21: after POR and OTP load, enter standby
// RL22: result holds until next measurement finishes
package bcslm_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_MEAS_SEL = 8'h00;
  localparam logic [7:0] ADR_LOAD_LO = 8'h04;
  localparam logic [7:0] ADR_LOAD_HI = 8'h08;
  localparam logic [7:0] ADR_INT_TOP = 8'h0C;
  localparam logic [7:0] ADR_MASK_TOP = 8'h10;
  localparam logic [7:0] ADR_PLL_CTRL = 8'h14;
  localparam logic [7:0] ADR_CONFIG = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1C;
  localparam logic [7:0] ADR_VOUT0 = 8'h20;
  localparam logic [7:0] ADR_VOUT1 = 8'h24;
  localparam logic [7:0] ADR_CTRL0 = 8'h28;
  localparam logic [7:0] ADR_CTRL1 = 8'h2C;
  localparam logic [7:0] ADR_DELAY0 = 8'h30;
  localparam logic [7:0] ADR_DELAY1 = 8'h34;
  // field positions
  localparam int FLAG_MEAS = 0;
  localparam int FLAG_SYNC = 1;
  localparam int PLL_EN_BIT = 7;
  localparam int CTRL_FPWM_BIT = 0;
  // reset values of host-owned registers
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic PLL_EN_RST = 1'h0;
  localparam logic [4:0] REF_SEL_RST = 5'h00;
  localparam logic DITHER_RST = 1'h0;
  // nominal select codes, window and load figures
  localparam logic [4:0] REF_SEL_MAX = 5'h17;
  localparam int REF_LO_PCT = 70;
  localparam int REF_HI_PCT = 110;
  localparam int LOAD_LSB_MA = 20;
  localparam int LOAD_PWM_MA = 600;
  // timing
  localparam int CLK_MHZ = 20;
  localparam int MEAS_MAX_NS = 50000;
  localparam int MEAS_CYC = MEAS_MAX_NS * CLK_MHZ / 1000;
  localparam int SETTLE_NS = 10000;
  localparam int SETTLE_CYC = SETTLE_NS * CLK_MHZ / 1000;
  localparam int WIN_NS = 10000;
  localparam int WIN_CYC = WIN_NS * CLK_MHZ / 1000;
  localparam int HOST_WAIT_NS = 1200000;
  localparam int HOST_WAIT_CYC = (HOST_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int OTP_LOAD_CYC = 16;
endpackage
